// ===== rtl/brru_byte_rotate_right_unit.v
// Added by the designer: the register offsets and the AHB-Lite register port.
`include "brru_consts.vh"
`default_nettype none

// Summary of operation
// RQ1: Through-carry rotate right; updates carry, negative, zero
// RQ2: Plain rotate right, bit0 to bit7; carry kept
// RQ3: Destination bit 0 to work, 1 to file
// RQ4: Bank bit 0 access bank, 1 bank pointer
// RQ5: Extended set, bank 0, f<=95: indexed offset
// RQ6: Decode 001100/010000 opcodes, one instruction cycle
module brru_byte_rotate_right_unit #(
    parameter ADDR_W = 12
) (
    input  wire        clock_i,
    input  wire        rst_i,
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output reg         hreadyout_o,
    output reg  [31:0] hrdata_o,
    output reg         hresp_o
);

    localparam DEPTH = 1 << ADDR_W;

    reg  [7:0]        file_mem [0:DEPTH-1];

    reg               ph_wr_ff;
    reg               ph_rd_ff;
    reg  [7:0]        ph_addr_ff;
    reg               exec_ff;
    reg               ext_en_ff;
    reg  [15:0]       instr_ff;
    reg  [7:0]        work_ff;
    reg  [3:0]        bank_pointer_ff;
    reg  [ADDR_W-1:0] index_base_ff;
    reg  [ADDR_W-1:0] mem_addr_ff;
    reg  [ADDR_W-1:0] last_addr_ff;
    reg               carry_ff;
    reg               zero_ff;
    reg               neg_ff;
    reg               bad_op_ff;
    reg               indexed_ff;
    reg  [31:0]       nxt_rdata;

    wire              accept;
    wire              wr_commit;
    wire              wr_instr;
    wire [5:0]        opcode;
    wire              dest_file;
    wire              bank_sel;
    wire [7:0]        file_ofs;
    wire              is_via_flag;
    wire              is_plain;
    wire              op_valid;
    wire              use_indexed;
    wire [ADDR_W-1:0] eff_addr;
    wire [7:0]        operand;
    wire [7:0]        rot_result;
    wire              rot_carry;
    wire              rot_neg;
    wire              rot_zero;

    // Access bank splits low RAM and the special page
    function [ADDR_W-1:0] access_addr;
        input [7:0] ofs;
        reg   [3:0] page;
        begin
            if (ofs <= `BRRU_ACCESS_LIMIT)
                page = `BRRU_LOW_PAGE;
            else
                page = `BRRU_SFR_PAGE;
            // Page sits above the offset, extended to the array width
            access_addr = {{(ADDR_W-8){1'b0}}, ofs}
                        | ({{(ADDR_W-4){1'b0}}, page} << 8);
        end
    endfunction

    function [31:0] zext12;
        input [ADDR_W-1:0] val;
        begin
            zext12 = {{(32-ADDR_W){1'b0}}, val};
        end
    endfunction

    assign accept    = hsel_i & htrans_i[1] & hready_i;
    assign wr_commit = ph_wr_ff & hready_i;
    assign wr_instr  = wr_commit & (ph_addr_ff == `BRRU_OFS_INSTR);

    assign opcode      = instr_ff[15:10];
    assign dest_file   = instr_ff[`BRRU_INSTR_D_BIT];
    assign bank_sel    = instr_ff[`BRRU_INSTR_A_BIT];
    assign file_ofs    = instr_ff[7:0];
    assign is_via_flag = (opcode == `BRRU_OP_ROT_VIA_FLAG); // RQ6
    assign is_plain    = (opcode == `BRRU_OP_ROT_PLAIN);    // RQ6
    assign op_valid    = is_via_flag | is_plain;

    assign use_indexed = ~bank_sel & ext_en_ff & (file_ofs <= `BRRU_ACCESS_LIMIT); // RQ5

    // Effective file address
    assign eff_addr = use_indexed ? (index_base_ff + {{(ADDR_W-8){1'b0}}, file_ofs}) // RQ5
                    : bank_sel    ? {bank_pointer_ff, file_ofs}                    // RQ4
                    :               access_addr(file_ofs);                         // RQ4

    assign operand = file_mem[eff_addr];

    brru_rotate u_rotate (
        .operand_i  (operand),
        .carry_i    (carry_ff),
        .via_flag_i (is_via_flag),
        .result_o   (rot_result),
        .carry_o    (rot_carry),
        .neg_o      (rot_neg),
        .zero_o     (rot_zero)
    );

    // Bus phase tracking
    always @(posedge clock_i) begin
        if (rst_i) begin
            ph_wr_ff   <= 1'b0;
            ph_rd_ff   <= 1'b0;
            ph_addr_ff <= 8'h00;
        end else if (accept) begin
            ph_wr_ff   <= hwrite_i;
            ph_rd_ff   <= ~hwrite_i;
            ph_addr_ff <= {haddr_i[7:2], 2'b00};
        end else if (hready_i) begin
            ph_wr_ff   <= 1'b0;
            ph_rd_ff   <= 1'b0;
        end
    end

    // Read mux, sampled during the stalled data phase
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (ph_addr_ff)
            `BRRU_OFS_CTRL: begin
                nxt_rdata[`BRRU_CTRL_EXT_BIT] = ext_en_ff;
            end
            `BRRU_OFS_INSTR: begin
                nxt_rdata = {16'h0000, instr_ff};
            end
            `BRRU_OFS_WORK: begin
                nxt_rdata = {24'h00_0000, work_ff};
            end
            `BRRU_OFS_BANK: begin
                nxt_rdata = {28'h000_0000, bank_pointer_ff};
            end
            `BRRU_OFS_STATUS: begin
                nxt_rdata[`BRRU_ST_CARRY_BIT]   = carry_ff;
                nxt_rdata[`BRRU_ST_ZERO_BIT]    = zero_ff;
                nxt_rdata[`BRRU_ST_NEG_BIT]     = neg_ff;
                nxt_rdata[`BRRU_ST_BADOP_BIT]   = bad_op_ff;
                nxt_rdata[`BRRU_ST_INDEXED_BIT] = indexed_ff;
            end
            `BRRU_OFS_INDEX: begin
                nxt_rdata = zext12(index_base_ff);
            end
            `BRRU_OFS_MEM_ADDR: begin
                nxt_rdata = zext12(mem_addr_ff);
            end
            `BRRU_OFS_MEM_DATA: begin
                nxt_rdata = {24'h00_0000, file_mem[mem_addr_ff]};
            end
            `BRRU_OFS_LAST_ADDR: begin
                nxt_rdata = zext12(last_addr_ff);
            end
            default: begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Ready, read data and response; reads wait out a pending execute
    always @(posedge clock_i) begin
        if (rst_i) begin
            hreadyout_o <= 1'b1;
            hrdata_o    <= 32'h0000_0000;
            hresp_o     <= 1'b0;
        end else begin
            hresp_o <= 1'b0;
            if (wr_instr) begin
                hreadyout_o <= 1'b0;
            end else if (accept & ~hwrite_i) begin
                hreadyout_o <= 1'b0;
            end else if (ph_rd_ff & ~hreadyout_o & ~exec_ff) begin
                hrdata_o    <= nxt_rdata;
                hreadyout_o <= 1'b1;
            end else if (~ph_rd_ff) begin
                hreadyout_o <= 1'b1;
            end
        end
    end

    // Software written registers
    always @(posedge clock_i) begin
        if (rst_i) begin
            ext_en_ff       <= `BRRU_RST_CTRL;
            instr_ff        <= `BRRU_RST_INSTR;
            bank_pointer_ff <= `BRRU_RST_BANK;
            index_base_ff   <= `BRRU_RST_INDEX;
            mem_addr_ff     <= {ADDR_W{1'b0}};
            exec_ff         <= 1'b0;
        end else begin
            exec_ff <= wr_instr; // RQ6
            if (wr_commit) begin
                case (ph_addr_ff)
                    `BRRU_OFS_CTRL: begin
                        ext_en_ff <= hwdata_i[`BRRU_CTRL_EXT_BIT];
                    end
                    `BRRU_OFS_INSTR: begin
                        instr_ff <= hwdata_i[15:0];
                    end
                    `BRRU_OFS_BANK: begin
                        bank_pointer_ff <= hwdata_i[3:0];
                    end
                    `BRRU_OFS_INDEX: begin
                        index_base_ff <= hwdata_i[ADDR_W-1:0];
                    end
                    `BRRU_OFS_MEM_ADDR: begin
                        mem_addr_ff <= hwdata_i[ADDR_W-1:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Working register and flags: bus writes and instruction results
    always @(posedge clock_i) begin
        if (rst_i) begin
            work_ff      <= `BRRU_RST_WORK;
            carry_ff     <= 1'b0;
            zero_ff      <= 1'b0;
            neg_ff       <= 1'b0;
            bad_op_ff    <= 1'b0;
            indexed_ff   <= 1'b0;
            last_addr_ff <= {ADDR_W{1'b0}};
        end else if (exec_ff) begin
            bad_op_ff <= ~op_valid; // RQ6
            if (op_valid) begin
                last_addr_ff <= eff_addr;
                indexed_ff   <= use_indexed; // RQ5
                zero_ff      <= rot_zero;    // RQ1 RQ2
                neg_ff       <= rot_neg;     // RQ1 RQ2
                carry_ff     <= rot_carry;   // RQ1 RQ2
                if (~dest_file)
                    work_ff <= rot_result;   // RQ3
            end
        end else if (wr_commit) begin
            if (ph_addr_ff == `BRRU_OFS_WORK)
                work_ff <= hwdata_i[7:0];
            if (ph_addr_ff == `BRRU_OFS_STATUS) begin
                carry_ff  <= hwdata_i[`BRRU_ST_CARRY_BIT];
                zero_ff   <= hwdata_i[`BRRU_ST_ZERO_BIT];
                neg_ff    <= hwdata_i[`BRRU_ST_NEG_BIT];
                bad_op_ff <= hwdata_i[`BRRU_ST_BADOP_BIT];
            end
        end
    end

    // File register array, one write port
    always @(posedge clock_i) begin
        if (exec_ff & op_valid & dest_file)
            file_mem[eff_addr] <= rot_result; // RQ3
        else if (wr_commit & (ph_addr_ff == `BRRU_OFS_MEM_DATA))
            file_mem[mem_addr_ff] <= hwdata_i[7:0];
    end

endmodule

`default_nettype wire

// ===== rtl/brru_consts.vh
`ifndef BRRU_CONSTS_VH
`define BRRU_CONSTS_VH

// Register byte offsets, word aligned
`define BRRU_OFS_CTRL       8'h00
`define BRRU_OFS_INSTR      8'h04
`define BRRU_OFS_WORK       8'h08
`define BRRU_OFS_BANK       8'h0c
`define BRRU_OFS_STATUS     8'h10
`define BRRU_OFS_INDEX      8'h14
`define BRRU_OFS_MEM_ADDR   8'h18
`define BRRU_OFS_MEM_DATA   8'h1c
`define BRRU_OFS_LAST_ADDR  8'h20

// Field positions
`define BRRU_CTRL_EXT_BIT   0
`define BRRU_ST_CARRY_BIT   0
`define BRRU_ST_ZERO_BIT    1
`define BRRU_ST_NEG_BIT     2
`define BRRU_ST_BADOP_BIT   8
`define BRRU_ST_INDEXED_BIT 9
`define BRRU_INSTR_D_BIT    9
`define BRRU_INSTR_A_BIT    8

// Reset values
`define BRRU_RST_CTRL       1'h0
`define BRRU_RST_WORK       8'h00
`define BRRU_RST_BANK       4'h0
`define BRRU_RST_INDEX      12'h000
`define BRRU_RST_INSTR      16'h0000

// Opcodes, upper six instruction bits
`define BRRU_OP_ROT_VIA_FLAG 6'h0c
`define BRRU_OP_ROT_PLAIN    6'h10

// Addressing
`define BRRU_ACCESS_LIMIT   8'h5f
`define BRRU_SFR_PAGE       4'hf
`define BRRU_LOW_PAGE       4'h0

`endif

// ===== rtl/brru_rotate.v
`default_nettype none

module brru_rotate (
    input  wire [7:0] operand_i,
    input  wire       carry_i,
    input  wire       via_flag_i,
    output reg  [7:0] result_o,
    output reg        carry_o,
    output reg        neg_o,
    output reg        zero_o
);

    always @* begin
        if (via_flag_i) begin
            result_o = {carry_i, operand_i[7:1]}; // RQ1
            carry_o  = operand_i[0];              // RQ1
        end else begin
            result_o = {operand_i[0], operand_i[7:1]}; // RQ2
            carry_o  = carry_i;                        // RQ2
        end
        neg_o  = result_o[7];
        zero_o = (result_o == 8'h00);
    end

endmodule

`default_nettype wire

// ===== test/brru_chk_sva.sv
`include "brru_consts.vh"
`default_nettype none
module brru_chk (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic        hready_i,
    input wire logic        hreadyout_o,
    input wire logic [31:0] hrdata_o,
    input wire logic        hresp_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire acc = hsel_i & htrans_i[1] & hready_i;
    wire ins = haddr_i[7:0] == `BRRU_OFS_INSTR;
    okay_resp_a: assert property (hresp_o == 1'b0)
        else $error("Response not OKAY");
    instr_stall_a: assert property (acc && hwrite_i && ins |=>
        hreadyout_o ##1 !hreadyout_o ##1 hreadyout_o)
        else $error("Execute stall not one cycle");
    plain_write_a: assert property (acc && hwrite_i && !ins |=> hreadyout_o)
        else $error("Register write stalled");
    read_wait_a: assert property (acc && !hwrite_i |=>
        !hreadyout_o ##[1:2] hreadyout_o)
        else $error("Read wait out of range");
    wait_limit_a: assert property (!hreadyout_o ##1 !hreadyout_o |=> hreadyout_o)
        else $error("More than two wait cycles");
    rdata_hold_a: assert property (!$rose(hreadyout_o) |-> $stable(hrdata_o))
        else $error("Read data changed outside a read");
    reset_state_a: assert property ($fell(rst_i) |->
        hreadyout_o && hrdata_o == 32'h0)
        else $error("Bus outputs wrong after reset");
endmodule
bind brru_byte_rotate_right_unit brru_chk u_chk (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hready_i    (hready_i),
    .hreadyout_o (hreadyout_o),
    .hrdata_o    (hrdata_o),
    .hresp_o     (hresp_o)
);
`default_nettype wire

// ===== test/tb_byte_rotate_right_unit.sv
`include "brru_consts.vh"
`default_nettype none
module tb_byte_rotate_right_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i = 1'b0;
    logic        rst_i;
    logic [31:0] haddr_i;
    logic [1:0]  htrans_i;
    logic        hwrite_i;
    logic [31:0] hwdata_i;
    wire         hreadyout_o;
    wire  [31:0] hrdata_o;
    wire         hresp_o;
    int          num_errors = 0;
    int          cmp_count = 0;
    always #10 clock_i = ~clock_i;
    brru_byte_rotate_right_unit DUT (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .hsel_i      (1'b1),
        .haddr_i     (haddr_i),
        .htrans_i    (htrans_i),
        .hwrite_i    (hwrite_i),
        .hsize_i     (3'h2),
        .hwdata_i    (hwdata_i),
        .hready_i    (hreadyout_o),
        .hreadyout_o (hreadyout_o),
        .hrdata_o    (hrdata_o),
        .hresp_o     (hresp_o)
    );
    task complete_run;
        if (num_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wt;
        int n;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 40);
        if (hreadyout_o !== 1'b1) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, hreadyout_o, 1'b1);
            num_errors++;
            complete_run;
        end
    endtask
    task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
        haddr_i  <= {24'h0, a};
        hwrite_i <= w;
        htrans_i <= 2'h2;
        wt;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        wt;
        q = hrdata_o;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xf(a, 1'b1, d, q);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xf(a, 1'b0, 32'h0, q);
        cmp_count++;
        if (q !== e) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, q, e);
            num_errors++;
        end
    endtask
    task automatic ex(input logic [31:0] ad, input logic [31:0] v, input logic [31:0] ins);
        wr(`BRRU_OFS_MEM_ADDR, ad);
        wr(`BRRU_OFS_MEM_DATA, v);
        wr(`BRRU_OFS_INSTR, ins);
    endtask
    task automatic t_reset;
        for (int i = 0; i < 7; i++)
            rc(8'(i * 4), 32'h0);
        rc(`BRRU_OFS_LAST_ADDR, 32'h0);
        rc(8'h40, 32'h0);
    endtask
    // Bank pointer page, result to working register, carry in and out
    task automatic s_via;
        wr(`BRRU_OFS_BANK, 32'h3);
        wr(`BRRU_OFS_STATUS, 32'h0);
        ex(32'h3a5, 32'he6, 32'h31a5);
        rc(`BRRU_OFS_WORK, 32'h73);
        rc(`BRRU_OFS_STATUS, 32'h0);
        rc(`BRRU_OFS_MEM_DATA, 32'he6);
        rc(`BRRU_OFS_LAST_ADDR, 32'h3a5);
        wr(`BRRU_OFS_STATUS, 32'h1);
        ex(32'h3a5, 32'h01, 32'h31a5);
        rc(`BRRU_OFS_WORK, 32'h80);
        rc(`BRRU_OFS_STATUS, 32'h5);
    endtask
    // Access bank upper page with carry kept, then low page through carry, results back to file
    task automatic s_plain;
        wr(`BRRU_OFS_WORK, 32'h55);
        wr(`BRRU_OFS_STATUS, 32'h1);
        ex(32'hf60, 32'hd7, 32'h4260);
        rc(`BRRU_OFS_MEM_DATA, 32'heb);
        rc(`BRRU_OFS_WORK, 32'h55);
        rc(`BRRU_OFS_STATUS, 32'h5);
        rc(`BRRU_OFS_LAST_ADDR, 32'hf60);
        ex(32'h010, 32'h02, 32'h3210);
        rc(`BRRU_OFS_MEM_DATA, 32'h81);
        rc(`BRRU_OFS_STATUS, 32'h4);
        rc(`BRRU_OFS_LAST_ADDR, 32'h010);
    endtask
    // Indexed offset at the 0x5f boundary and just past it
    task automatic s_index;
        wr(`BRRU_OFS_CTRL, 32'h1);
        wr(`BRRU_OFS_INDEX, 32'h200);
        wr(`BRRU_OFS_STATUS, 32'h1);
        ex(32'h25f, 32'h00, 32'h405f);
        rc(`BRRU_OFS_WORK, 32'h0);
        rc(`BRRU_OFS_STATUS, 32'h203);
        rc(`BRRU_OFS_LAST_ADDR, 32'h25f);
        ex(32'hf60, 32'h02, 32'h4260);
        rc(`BRRU_OFS_MEM_DATA, 32'h01);
        rc(`BRRU_OFS_STATUS, 32'h1);
        rc(`BRRU_OFS_LAST_ADDR, 32'hf60);
        // Bank bit set: no indexing even with the extended set on
        ex(32'h310, 32'h04, 32'h3110);
        rc(`BRRU_OFS_LAST_ADDR, 32'h310);
        rc(`BRRU_OFS_STATUS, 32'h4);
        rc(`BRRU_OFS_WORK, 32'h82);
    endtask
    // Unknown opcode flags only; a valid one clears the flag
    task automatic s_bad;
        wr(`BRRU_OFS_WORK, 32'h5a);
        wr(`BRRU_OFS_STATUS, 32'h0);
        wr(`BRRU_OFS_INSTR, 32'hfc00);
        rc(`BRRU_OFS_STATUS, 32'h100);
        rc(`BRRU_OFS_WORK, 32'h5a);
        rc(`BRRU_OFS_INSTR, 32'hfc00);
        ex(32'h3a5, 32'h00, 32'h31a5);
        rc(`BRRU_OFS_STATUS, 32'h2);
    endtask
    initial begin
        rst_i    = 1'b1;
        haddr_i  = 32'h0;
        htrans_i = 2'h0;
        hwrite_i = 1'b0;
        hwdata_i = 32'h0;
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        t_reset;
        s_via;
        s_plain;
        s_index;
        s_bad;
        complete_run;
    end
endmodule
`default_nettype wire
